/* core/ccs_exec.sv */
// Execution unit for the invert-to-target and equal-compare-skip instructions
//
// Notes on behaviour
// - Invert reads the addressed data byte and produces its bitwise inverse.
// - With destination bit 0 the inverse goes to the working register only.
// - With destination bit 1 the inverse is written back to the source byte.
// - With bank bit 0 the fixed access bank is used and the bank pointer ignored.
// - With bank bit 1 the bank pointer register supplies the upper address bits.
// - Compare subtracts the working register from the byte, changing no flag or register.
// - On equality the fetched next instruction is dropped and an idle cycle runs.
// - Compare takes one cycle without skip and two with skip.
// - Skipping a two-word instruction costs two idle cycles, three in all.
// - The skip condition is a zero result of the compare subtraction.
`default_nettype none
module ccs_exec #(
  parameter int Q_DIV = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  // Fetch stage
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic next_two_word_i,
  output logic instr_take_o,
  // Data memory, one clock read latency
  output logic [11:0] dm_addr_o,
  output logic dm_re_o,
  input wire logic [7:0] dm_rdata_i,
  output logic dm_we_o,
  output logic [7:0] dm_wdata_o,
  // Cycle status
  output logic nop_cycle_o,
  output logic skip_o
);
  // ==========================================================
  // Phase timing
  logic q_en;
  logic [1:0] phase;

  ccs_qphase #(
    .DIV(Q_DIV)
  ) u_qphase (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .q_en_o(q_en),
    .phase_o(phase)
  );

  logic at_q1;
  logic at_q3;
  logic at_q4;
  assign at_q1 = q_en && (phase == ccs_pkg::PH_Q1);
  assign at_q3 = q_en && (phase == ccs_pkg::PH_Q3);
  assign at_q4 = q_en && (phase == ccs_pkg::PH_Q4);
  // Q2 needs no strobe of its own: the read is launched from decode

  // ==========================================================
  // State
  ccs_pkg::ccs_state_t st_q;
  ccs_pkg::ccs_state_t st_d;
  logic [7:0] work_q;
  logic [7:0] work_d;
  logic [3:0] bank_q;
  logic [3:0] bank_d;
  logic [1:0] flags_q;
  logic [1:0] flags_d;
  logic run_q;
  logic run_d;
  logic [7:0] fadr_q;
  logic [7:0] fadr_d;
  logic dest_q;
  logic dest_d;
  logic [7:0] rdat_q;
  logic [7:0] rdat_d;
  logic [7:0] diff_q;
  logic [7:0] diff_d;
  logic eq_q;
  logic eq_d;
  logic [1:0] skip_cnt_q;
  logic [1:0] skip_cnt_d;
  logic [11:0] addr_q;
  logic [11:0] addr_d;
  logic re_q;
  logic re_d;
  logic we_q;
  logic we_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic skip_q;
  logic skip_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdbk_q;
  logic [31:0] rdbk_d;

  // ==========================================================
  // Decode and operand address
  logic is_inv;
  logic is_ceq;
  logic [7:0] f_field;
  logic [11:0] op_addr;
  logic [7:0] inv_res;
  logic take;
  logic bus_req;
  logic bus_wr;

  assign is_inv = (instr_i[15:10] == ccs_pkg::OPC_INVERT);
  assign is_ceq = (instr_i[15:9] == ccs_pkg::OPC_EQSKIP);
  assign f_field = instr_i[7:0];

  always_comb begin
    if (instr_i[ccs_pkg::BANK_BIT]) begin
      op_addr = {bank_q, f_field};
    end else if (f_field < ccs_pkg::ACCESS_SPLIT) begin
      op_addr = {ccs_pkg::ACCESS_LO_BANK, f_field};
    end else begin
      op_addr = {ccs_pkg::ACCESS_HI_BANK, f_field};
    end
  end

  // Bitwise inverse of the fetched byte
  assign inv_res = ~rdat_q;

  // Any other opcode is consumed without effect, so its cycle stays idle
  // A pending skip consumes the fetched word even when the unit is stopped
  assign take = at_q1 && instr_valid_i && (run_q || (skip_cnt_q != 2'h0));
  assign instr_take_o = take;

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

  // ==========================================================
  // Instruction sequencing
  // Decode at Q1, read issued for Q2, data captured at Q3, results land at Q4.
  // Idle cycles count down one per Q1 edge, so a stalled fetch cannot
  // stretch a skip beyond one or two instruction cycles; the fetch side
  // must still offer the words it wants thrown away.
  always_comb begin
    st_d = st_q;
    fadr_d = fadr_q;
    dest_d = dest_q;
    rdat_d = rdat_q;
    diff_d = diff_q;
    eq_d = eq_q;
    skip_cnt_d = skip_cnt_q;
    addr_d = addr_q;
    re_d = 1'b0;
    we_d = 1'b0;
    wdata_d = wdata_q;
    skip_d = 1'b0;
    if (at_q1) begin
      st_d = ccs_pkg::CCS_ST_IDLE;
      if (skip_cnt_q != 2'h0) begin
        // Fetched word discarded, idle cycle in its place
        st_d = ccs_pkg::CCS_ST_NOP;
        skip_cnt_d = skip_cnt_q - 2'h1;
      end else if (take && (is_inv || is_ceq)) begin
        st_d = is_inv ? ccs_pkg::CCS_ST_INV : ccs_pkg::CCS_ST_CEQ;
        fadr_d = f_field;
        dest_d = instr_i[ccs_pkg::DEST_BIT];
        addr_d = op_addr;
        // Read issued in decode so data is back for the process phase
        re_d = 1'b1;
      end
    end
    case (st_q)
      ccs_pkg::CCS_ST_INV: begin
        // Memory answers one clock after the read strobe
        if (at_q3) begin
          rdat_d = dm_rdata_i;
        end
        // Write back to source on destination 1
        if (at_q4 && dest_q) begin
          we_d = 1'b1;
          wdata_d = inv_res;
        end
      end
      ccs_pkg::CCS_ST_CEQ: begin
        if (at_q3) begin
          rdat_d = dm_rdata_i;
          // Unsigned subtract, result kept for status and the skip test
          diff_d = dm_rdata_i - work_q;
        end
        if (at_q4) begin
          eq_d = (diff_q == 8'h00);
          if (diff_q == 8'h00) begin
            // One idle cycle for a one-word successor
            // Two idle cycles for a two-word successor
            if (next_two_word_i) begin
              skip_cnt_d = ccs_pkg::SKIP_TWO_WORD;
            end else begin
              skip_cnt_d = ccs_pkg::SKIP_ONE_WORD;
            end
            skip_d = 1'b1;
          end
        end
      end
      ccs_pkg::CCS_ST_IDLE, ccs_pkg::CCS_ST_NOP: begin
      end
      default: begin
        st_d = ccs_pkg::CCS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ccs_pkg::CCS_ST_IDLE;
      fadr_q <= 8'h00;
      dest_q <= 1'b0;
      rdat_q <= 8'h00;
      diff_q <= 8'h00;
      eq_q <= 1'b0;
      skip_cnt_q <= 2'h0;
      addr_q <= 12'h000;
      re_q <= 1'b0;
      we_q <= 1'b0;
      wdata_q <= 8'h00;
      skip_q <= 1'b0;
    end else begin
      st_q <= st_d;
      fadr_q <= fadr_d;
      dest_q <= dest_d;
      rdat_q <= rdat_d;
      diff_q <= diff_d;
      eq_q <= eq_d;
      skip_cnt_q <= skip_cnt_d;
      addr_q <= addr_d;
      re_q <= re_d;
      we_q <= we_d;
      wdata_q <= wdata_d;
      skip_q <= skip_d;
    end
  end

  // ==========================================================
  // Architectural registers: core update wins over a bus write
  always_comb begin
    work_d = work_q;
    bank_d = bank_q;
    flags_d = flags_q;
    run_d = run_q;
    if (bus_wr) begin
      case (wb_adr_i)
        ccs_pkg::ADR_WORK: work_d = wb_dat_i[7:0];
        ccs_pkg::ADR_BANK: bank_d = wb_dat_i[3:0];
        ccs_pkg::ADR_FLAGS: flags_d = wb_dat_i[1:0];
        ccs_pkg::ADR_CTRL: run_d = wb_dat_i[ccs_pkg::CTRL_RUN];
        ccs_pkg::ADR_STAT: begin
          // Status is read only; writes are acknowledged and dropped
        end
        default: begin
        end
      endcase
    end
    if (at_q4 && (st_q == ccs_pkg::CCS_ST_INV)) begin
      // Destination 0 loads the working register
      if (!dest_q) begin
        work_d = inv_res;
      end
      // Only sign and zero flags change
      flags_d[ccs_pkg::FLAG_Z] = (inv_res == 8'h00);
      flags_d[ccs_pkg::FLAG_N] = inv_res[ccs_pkg::SIGN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      work_q <= ccs_pkg::WORK_RST;
      bank_q <= ccs_pkg::BANK_RST;
      flags_q <= ccs_pkg::FLAGS_RST;
      run_q <= ccs_pkg::CTRL_RUN_RST;
    end else begin
      work_q <= work_d;
      bank_q <= bank_d;
      flags_q <= flags_d;
      run_q <= run_d;
    end
  end

  // ==========================================================
  // Wishbone answer: one wait state, unmapped reads give zero
  always_comb begin
    ack_d = bus_req;
    rdbk_d = rdbk_q;
    if (bus_req) begin
      rdbk_d = 32'h0000_0000;
      // Reads show the registers as they stand at the request edge
      case (wb_adr_i)
        ccs_pkg::ADR_WORK: rdbk_d[7:0] = work_q;
        ccs_pkg::ADR_BANK: rdbk_d[3:0] = bank_q;
        ccs_pkg::ADR_FLAGS: rdbk_d[1:0] = flags_q;
        ccs_pkg::ADR_CTRL: rdbk_d[ccs_pkg::CTRL_RUN] = run_q;
        ccs_pkg::ADR_STAT: begin
          rdbk_d[7:0] = diff_q;
          rdbk_d[ccs_pkg::STAT_EQ] = eq_q;
          rdbk_d[ccs_pkg::STAT_SKIP_LO +: 2] = skip_cnt_q;
          rdbk_d[ccs_pkg::STAT_NOP] = (st_q == ccs_pkg::CCS_ST_NOP);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdbk_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      rdbk_q <= rdbk_d;
    end
  end

  // ==========================================================
  // Outputs

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdbk_q;
  assign dm_addr_o = addr_q;
  assign dm_re_o = re_q;
  assign dm_we_o = we_q;
  assign dm_wdata_o = wdata_q;
  assign nop_cycle_o = (st_q == ccs_pkg::CCS_ST_NOP);
  assign skip_o = skip_q;
endmodule : ccs_exec
`default_nettype wire

/* core/ccs_pkg.sv */
// Constants shared by the complement and compare-skip execution block
`default_nettype none
package ccs_pkg;
  // ==========================================================
  // Register map, byte addresses on the Wishbone slave
  localparam logic [7:0] ADR_WORK = 8'h00;
  localparam logic [7:0] ADR_BANK = 8'h04;
  localparam logic [7:0] ADR_FLAGS = 8'h08;
  localparam logic [7:0] ADR_CTRL = 8'h0c;
  localparam logic [7:0] ADR_STAT = 8'h10;

  // ==========================================================
  // Reset values
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [1:0] FLAGS_RST = 2'h0;
  localparam logic CTRL_RUN_RST = 1'b0;

  // ==========================================================
  // Field positions
  localparam int FLAG_Z = 0;
  localparam int FLAG_N = 1;
  localparam int CTRL_RUN = 0;
  localparam int STAT_EQ = 8;
  localparam int STAT_SKIP_LO = 9;
  localparam int STAT_NOP = 11;
  localparam int SIGN_BIT = 7;

  // ==========================================================
  // Instruction word layout
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam logic [5:0] OPC_INVERT = 6'h07;
  localparam logic [6:0] OPC_EQSKIP = 7'h31;

  // Access bank split point and the bank used above it
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

  // ==========================================================
  // Phases of one instruction cycle and idle cycle counts
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [1:0] SKIP_ONE_WORD = 2'h1;
  localparam logic [1:0] SKIP_TWO_WORD = 2'h2;

  typedef enum logic [3:0] {
    CCS_ST_IDLE = 4'b0001,
    CCS_ST_INV = 4'b0010,
    CCS_ST_CEQ = 4'b0100,
    CCS_ST_NOP = 4'b1000
  } ccs_state_t;
endpackage : ccs_pkg
`default_nettype wire

/* core/ccs_qphase.sv */
// Quarter phase divider for the instruction cycle
`default_nettype none
module ccs_qphase #(
  parameter int DIV = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic q_en_o,
  output logic [1:0] phase_o
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [1:0] ph_q;
  logic [1:0] ph_d;
  logic tick;

  assign tick = (cnt_q == CNT_LAST);

  always_comb begin
    cnt_d = tick ? '0 : cnt_q + 1'b1;
    ph_d = tick ? ph_q + 2'h1 : ph_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      ph_q <= ccs_pkg::PH_Q1;
    end else begin
      cnt_q <= cnt_d;
      ph_q <= ph_d;
    end
  end

  assign q_en_o = tick;
  assign phase_o = ph_q;
endmodule : ccs_qphase
`default_nettype wire

/* sim/ccs_exec_checker.sv */
// Assertion checker for the complement and compare-skip execution block
`default_nettype none
module ccs_exec_checker #(
  parameter int Q_DIV = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [15:0] instr_i,
  input wire logic instr_take_o,
  input wire logic [11:0] dm_addr_o,
  input wire logic dm_re_o,
  input wire logic [7:0] dm_rdata_i,
  input wire logic dm_we_o,
  input wire logic [7:0] dm_wdata_o,
  input wire logic nop_cycle_o,
  input wire logic skip_o
);
  // ==========
  // Idle run length, measured in clocks
  logic [3:0] nc_q;
  logic [3:0] nc_d;
  logic op_inv;
  logic op_ceq;
  logic real_take;
  assign op_inv = instr_i[15:10] == ccs_pkg::OPC_INVERT;
  assign op_ceq = instr_i[15:9] == ccs_pkg::OPC_EQSKIP;
  // Words swallowed by idle cycles must not count as instructions
  assign real_take = instr_take_o && !skip_o && !nop_cycle_o;
  always_comb begin
    nc_d = nop_cycle_o ? nc_q + 4'h1 : 4'h0;
  end
  always_ff @(posedge clk_i) begin
    nc_q <= rst_i ? 4'h0 : nc_d;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // Properties
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus request not acknowledged");
  property p_read;
    real_take && (op_inv || op_ceq) |=> dm_re_o;
  endproperty
  a_read: assert property (p_read) else $error("no operand read");
  property p_cmp;
    real_take && op_ceq |-> ##4 !dm_we_o;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare wrote memory");
  property p_acc;
    dm_re_o && !$past(instr_i[8]) |-> dm_addr_o == {$past(instr_i[7]) ?
      ccs_pkg::ACCESS_HI_BANK : ccs_pkg::ACCESS_LO_BANK, $past(instr_i[7:0])};
  endproperty
  a_acc: assert property (p_acc) else $error("access bank address wrong");
  property p_wdat;
    dm_we_o |-> dm_wdata_o == ~$past(dm_rdata_i, 2);
  endproperty
  a_wdat: assert property (p_wdat) else $error("written byte not inverse");
  property p_wadr;
    dm_we_o |-> $past(dm_re_o, 3) && dm_addr_o == $past(dm_addr_o, 3);
  endproperty
  a_wadr: assert property (p_wadr) else $error("write not to source");
  property p_idle;
    skip_o |=> (nop_cycle_o && !dm_re_o && !dm_we_o) [*4];
  endproperty
  a_idle: assert property (p_idle) else $error("idle cycle not idle");
  property p_src;
    skip_o |-> $past(instr_take_o, 4) && $past(op_ceq, 4);
  endproperty
  a_src: assert property (p_src) else $error("skip without compare");
  property p_span;
    $fell(nop_cycle_o) |-> nc_q == 4'h4 || nc_q == 4'h8;
  endproperty
  a_span: assert property (p_span) else $error("idle span length wrong");
  c_skip: cover property (skip_o);
  c_two: cover property ($fell(nop_cycle_o) && nc_q == 4'h8);
  c_wr: cover property (dm_we_o);
endmodule : ccs_exec_checker
bind ccs_exec ccs_exec_checker #(.Q_DIV(Q_DIV)) u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .instr_i, .instr_take_o, .dm_addr_o, .dm_re_o, .dm_rdata_i, .dm_we_o,
  .dm_wdata_o, .nop_cycle_o, .skip_o);
`default_nettype wire

/* sim/ccs_exec_tb.sv */
// Self-checking testbench for the complement and compare-skip execution block
`default_nettype none
module ccs_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic instr_valid_i = 1'b0, next_two_word_i = 1'b0;
  logic [7:0] dm_rdata_i = 8'h00;
  logic [31:0] wb_dat_o;
  logic [11:0] dm_addr_o;
  logic [7:0] dm_wdata_o;
  logic wb_ack_o, instr_take_o, dm_re_o, dm_we_o, nop_cycle_o, skip_o;
  logic [7:0] mem [4096];
  int seed = 76;
  int failures = 0, tests_run = 0, nop_n = 0, skip_n = 0;
  ccs_exec #(.Q_DIV(1)) dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
    .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .instr_i, .instr_valid_i, .next_two_word_i,
    .instr_take_o, .dm_addr_o, .dm_re_o, .dm_rdata_i, .dm_we_o, .dm_wdata_o, .nop_cycle_o,
    .skip_o);
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // ==========
  // Data memory; read data is scrambled once its hold window has passed
  always @(posedge clk_i) begin
    if (dm_we_o) mem[dm_addr_o] <= dm_wdata_o;
    if (dm_re_o) dm_rdata_i <= mem[dm_addr_o];
    else if (instr_take_o) dm_rdata_i <= ~dm_rdata_i;
    nop_n <= nop_n + int'(nop_cycle_o);
    skip_n <= skip_n + int'(skip_o);
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d,
                    output logic [31:0] q);
    wb_adr_i <= a;
    wb_we_i <= we;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    // No cycle count assumed; the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // Hold the word until the core consumes it at a Q1 edge
  task automatic feed(input logic [15:0] w);
    instr_i <= w;
    instr_valid_i <= 1'b1;
    do begin
      @(negedge clk_i);
    end while (instr_take_o !== 1'b1);
    @(posedge clk_i);
  endtask : feed
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    tally_and_finish();
  end
  initial begin
    logic [31:0] q;
    logic [7:0] w, v, f, r;
    logic [3:0] b;
    logic [1:0] fl;
    logic op, a, d, two, eq;
    logic [11:0] ad;
    int n0, s0;
    for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 37 + 5);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(8'h14, 1'b1, 32'hff, q);
    for (int k = 0; k < 6; k++) begin
      wb(8'(k * 4), 1'b0, 32'h0, q);
      chk("reset or unmapped read", q, 32'h0);
    end
    wb(ccs_pkg::ADR_CTRL, 1'b1, 32'h1, q);
    for (int i = 0; i < 40; i++) begin
      {w, v, f, b, op, a, d, two} = 32'($random(seed));
      if (i == 0) {op, v, two} = {1'b1, w, 1'b1};
      if (i == 1) {op, a, v, f} = {1'b0, 1'b0, 8'hff, 8'h80};
      if (op && seed[0]) v = w;
      // The scratch byte catches a skipped follower
      if (f == 8'h7f) f = 8'h7e;
      ad = a ? {b, f} : {f[7] ? ccs_pkg::ACCESS_HI_BANK : ccs_pkg::ACCESS_LO_BANK, f};
      mem[ad] = v;
      mem[12'h07f] = 8'h00;
      wb(ccs_pkg::ADR_WORK, 1'b1, {24'h0, w}, q);
      wb(ccs_pkg::ADR_BANK, 1'b1, {28'h0, b}, q);
      wb(ccs_pkg::ADR_FLAGS, 1'b1, 32'h0, q);
      n0 = nop_n;
      s0 = skip_n;
      eq = op && v == w;
      r = ~v;
      next_two_word_i <= two;
      feed(op ? {ccs_pkg::OPC_EQSKIP, a, f} : {ccs_pkg::OPC_INVERT, d, a, f});
      repeat ((eq && two) ? 2 : 1) feed(op ? 16'h1e7f : 16'h0000);
      instr_valid_i <= 1'b0;
      next_two_word_i <= 1'b0;
      repeat (12) @(posedge clk_i);
      fl = op ? (eq ? 2'b00 : 2'b10) : {r[7], r == 8'h00};
      wb(ccs_pkg::ADR_WORK, 1'b0, 32'h0, q);
      chk("working register", q, {24'h0, (!op && !d) ? r : w});
      wb(ccs_pkg::ADR_FLAGS, 1'b0, 32'h0, q);
      chk("flags", q, {30'h0, fl});
      chk("target byte", {24'h0, mem[ad]}, {24'h0, (!op && d) ? r : v});
      chk("follower byte", {24'h0, mem[12'h07f]}, (op && !eq) ? 32'hff : 32'h0);
      chk("idle clocks", nop_n - n0, eq ? (two ? 32'h8 : 32'h4) : 32'h0);
      chk("skip pulses", skip_n - s0, {31'h0, eq});
      wb(ccs_pkg::ADR_STAT, 1'b0, 32'h0, q);
      if (op) chk("compare status", {23'h0, q[8:0]}, {23'h0, eq, 8'(v - w)});
      $display("test %0d done", i);
    end
    tally_and_finish();
  end
endmodule : ccs_exec_tb
`default_nettype wire
